// ===== verilog/hotplug_slot_status_pkg.sv
package hotplug_slot_status_pkg;
  localparam logic [7:0]  SLOT_STATUS_OFS   = 8'h5A;
  localparam logic [7:0]  DEV_CAP2_OFS      = 8'h64;
  localparam logic [7:0]  DEV_CTL2_OFS      = 8'h68;
  localparam logic [7:0]  SLOT_CTL_OFS      = 8'h58;
  localparam logic [7:0]  EVENT_ENABLE_OFS  = 8'h80;
  localparam int          BTN_BIT           = 0;
  localparam int          PFAULT_BIT        = 1;
  localparam int          LATCH_CHG_BIT     = 2;
  localparam int          PRES_CHG_BIT      = 3;
  localparam int          CMD_DONE_BIT      = 4;
  localparam int          LATCH_STATE_BIT   = 5;
  localparam int          PRES_STATE_BIT    = 6;
  localparam int          INTERLOCK_BIT     = 7;
  localparam int          LINK_CHG_BIT      = 8;
  localparam int          FWD_SUP_BIT       = 5;
  localparam int          FWD_EN_BIT        = 5;
  localparam int          GLOBAL_IE_BIT     = 5;
  localparam logic [8:0]  EVENT_MASK        = 9'h11F;
  localparam logic [12:0] EVENT_EN_MASK     = 13'h101F;
  localparam logic        LATCH_RESET       = 1'h0;
  localparam logic        PRES_RESET        = 1'h1;
  localparam logic        FWD_SUP_RESET     = 1'h1;
endpackage

// ===== verilog/hotplug_slot_status_flags.sv
`timescale 1ns/10ps
module hotplug_slot_status_flags #(
  parameter bit UPSTREAM_PORT      = 1'b0,
  parameter bit INTERLOCK_PRESENT  = 1'b1
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Avalon-MM slave, word addressed by byte address bits [7:2]
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Slot sensors from the expanders
  input  wire logic        button_pin,
  input  wire logic        power_fault_pin,
  input  wire logic        latch_open_pin,
  input  wire logic        presence_pin,
  input  wire logic        interlock_pin,
  // Link layer state, core clock
  input  wire logic        link_active_indication,
  // Expander command path
  output logic             cmd_issue,
  output logic      [15:0] cmd_data,
  input  wire logic        expander_busy,
  // Hot-plug interrupt
  output logic             hotplug_irq
);

  // ***********************************************************
  // State
  // ***********************************************************
  typedef enum logic [1:0] {cmd_idle, cmd_start, cmd_wait} cmd_state_type;

  typedef struct packed {
    logic [4:0]    sync_a;
    logic [4:0]    sync_b;
    logic          latch_state;
    logic          presence_state;
    logic          interlock_state;
    logic          button_prev;
    logic          fault_prev;
    logic          link_prev;
    logic [8:0]    flags;
    logic [15:0]   slot_ctl;
    logic [12:0]   event_en;
    logic          alt_routing_fwd_enable;
    cmd_state_type cmd_state;
    logic          cmd_issue;
    logic [15:0]   cmd_data;
    logic          ack;
    logic [31:0]   readdata;
    logic          irq;
  } state_type;

  state_type st;
  state_type next_st;

  logic [8:0]  events;
  logic [8:0]  clear;
  logic        wr_hit;
  logic        fwd_supported;
  logic [31:0] ctl_merged;
  logic [31:0] en_merged;

  // ***********************************************************
  // Next state
  // ***********************************************************
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    next_st = st;
    fwd_supported = !UPSTREAM_PORT && hotplug_slot_status_pkg::FWD_SUP_RESET;
    // Writes land at the edge that sees waitrequest low
    wr_hit = write && st.ack;
    ctl_merged = merge_bytes({16'h0000, st.slot_ctl}, writedata, byteenable);
    en_merged = merge_bytes({19'h00000, st.event_en}, writedata, byteenable);
    next_st.ack = (read || write) && !st.ack;
    next_st.sync_a = {interlock_pin, presence_pin, latch_open_pin,
                      power_fault_pin, button_pin};
    next_st.sync_b = st.sync_a;
    next_st.latch_state = st.sync_b[2];
    next_st.presence_state = st.sync_b[3];
    next_st.interlock_state = INTERLOCK_PRESENT && st.sync_b[4];
    next_st.button_prev = st.sync_b[0];
    next_st.fault_prev = st.sync_b[1];
    next_st.link_prev = link_active_indication;
    next_st.cmd_issue = 1'b0;

    events = '0;
    events[hotplug_slot_status_pkg::BTN_BIT] =
      st.sync_b[0] && !st.button_prev;
    events[hotplug_slot_status_pkg::PFAULT_BIT] =
      st.sync_b[1] && !st.fault_prev;
    events[hotplug_slot_status_pkg::LATCH_CHG_BIT] =
      st.sync_b[2] != st.latch_state;
    events[hotplug_slot_status_pkg::PRES_CHG_BIT] =
      st.sync_b[3] != st.presence_state;
    events[hotplug_slot_status_pkg::LINK_CHG_BIT] =
      link_active_indication != st.link_prev;

    // A slot control write issues one command only when no command is in flight
    unique case (st.cmd_state)
      cmd_idle: begin
        if (wr_hit && address[7:2] == hotplug_slot_status_pkg::SLOT_CTL_OFS[7:2]
            && byteenable[1:0] != 2'h0) begin
          next_st.cmd_state = cmd_start;
          next_st.cmd_issue = 1'b1;
          next_st.cmd_data = ctl_merged[15:0];
        end
      end
      cmd_start: begin
        next_st.cmd_state = cmd_wait;
      end
      cmd_wait: begin
        if (!expander_busy) begin
          next_st.cmd_state = cmd_idle;
          events[hotplug_slot_status_pkg::CMD_DONE_BIT] = 1'b1;
        end
      end
      default: begin
        next_st.cmd_state = cmd_idle;
      end
    endcase

    clear = '0;
    if (wr_hit && address[7:2] == hotplug_slot_status_pkg::SLOT_STATUS_OFS[7:2]) begin
      // 0x5A sits in upper half of word 0x58
      if (byteenable[2]) clear[7:0] = writedata[23:16];
      if (byteenable[3]) clear[8] = writedata[24];
    end
    next_st.flags = ((st.flags & ~clear) | events)
                    & hotplug_slot_status_pkg::EVENT_MASK;

    if (wr_hit && address[7:2] == hotplug_slot_status_pkg::SLOT_CTL_OFS[7:2]) begin
      next_st.slot_ctl = ctl_merged[15:0];
    end
    if (wr_hit && address[7:2] == hotplug_slot_status_pkg::EVENT_ENABLE_OFS[7:2]) begin
      next_st.event_en = en_merged[12:0]
                         & (hotplug_slot_status_pkg::EVENT_EN_MASK
                            | 13'h0020);
    end
    if (wr_hit && address[7:2] == hotplug_slot_status_pkg::DEV_CTL2_OFS[7:2]
        && byteenable[0]) begin
      next_st.alt_routing_fwd_enable =
        fwd_supported && writedata[hotplug_slot_status_pkg::FWD_EN_BIT];
    end
    if (!fwd_supported) next_st.alt_routing_fwd_enable = 1'b0;

    next_st.readdata = 32'h0000_0000;
    if (read && !st.ack) begin
      unique case (address[7:2])
        hotplug_slot_status_pkg::SLOT_CTL_OFS[7:2]:
          next_st.readdata = {7'h00, st.flags[8], st.interlock_state,
                              st.presence_state, st.latch_state,
                              st.flags[4:0], st.slot_ctl};
        hotplug_slot_status_pkg::DEV_CAP2_OFS[7:2]:
          next_st.readdata[hotplug_slot_status_pkg::FWD_SUP_BIT] =
            fwd_supported;
        hotplug_slot_status_pkg::DEV_CTL2_OFS[7:2]:
          next_st.readdata[hotplug_slot_status_pkg::FWD_EN_BIT] =
            st.alt_routing_fwd_enable;
        hotplug_slot_status_pkg::EVENT_ENABLE_OFS[7:2]:
          next_st.readdata = {19'h00000, st.event_en};
        default: next_st.readdata = 32'h0000_0000;
      endcase
    end

    next_st.irq = st.event_en[hotplug_slot_status_pkg::GLOBAL_IE_BIT] &&
                  |({st.event_en[12], st.event_en[4:0]} &
                    {st.flags[8], st.flags[4:0]});
  end

  // ***********************************************************
  // Registers
  // ***********************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.presence_state <= hotplug_slot_status_pkg::PRES_RESET;
      st.latch_state <= hotplug_slot_status_pkg::LATCH_RESET;
      st.sync_b <= 5'h08;
      st.sync_a <= 5'h08;
      st.cmd_state <= cmd_idle;
    end else begin
      st <= next_st;
    end
  end

  assign readdata    = st.readdata;
  assign waitrequest = (read || write) && !st.ack;
  assign cmd_issue   = st.cmd_issue;
  assign cmd_data    = st.cmd_data;
  assign hotplug_irq = st.irq;

  // ***********************************************************
  // Checks
  // ***********************************************************
  property p_clear_wins_not;
    @(posedge mclk) disable iff (!nrst)
      events[hotplug_slot_status_pkg::LINK_CHG_BIT] |=>
        st.flags[hotplug_slot_status_pkg::LINK_CHG_BIT];
  endproperty
  a_clear_wins_not: assert property (p_clear_wins_not)
    else $error("link change lost");

  property p_button;
    @(posedge mclk) disable iff (!nrst)
      $rose(st.sync_b[0]) |=> st.flags[0];
  endproperty
  a_button: assert property (p_button)
    else $error("button flag not set");

  property p_fault;
    @(posedge mclk) disable iff (!nrst)
      events[1] |=> st.flags[1];
  endproperty
  a_fault: assert property (p_fault)
    else $error("power fault flag not set");

  property p_latch;
    @(posedge mclk) disable iff (!nrst)
      $changed(st.latch_state) |-> st.flags[2];
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch change flag not set");

  property p_presence;
    @(posedge mclk) disable iff (!nrst)
      $changed(st.presence_state) |-> st.flags[3];
  endproperty
  a_presence: assert property (p_presence)
    else $error("presence change flag not set");

  property p_cmd_done;
    @(posedge mclk) disable iff (!nrst)
      (st.cmd_state == cmd_wait && !expander_busy) |=> st.flags[4];
  endproperty
  a_cmd_done: assert property (p_cmd_done)
    else $error("command done flag not set");

  property p_cmd_once;
    @(posedge mclk) disable iff (!nrst)
      st.cmd_issue |=> !st.cmd_issue;
  endproperty
  a_cmd_once: assert property (p_cmd_once)
    else $error("command issued twice");

  property p_fwd;
    @(posedge mclk) disable iff (!nrst)
      !fwd_supported |-> !st.alt_routing_fwd_enable;
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("forwarding enable set while unsupported");

  property p_irq;
    @(posedge mclk) disable iff (!nrst)
      !st.event_en[hotplug_slot_status_pkg::GLOBAL_IE_BIT] |=> !hotplug_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without global enable");

  property p_reserved;
    @(posedge mclk) disable iff (!nrst)
      st.ack && address[7:2] == 6'h16 |-> readdata[31:25] == 7'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bits nonzero");

endmodule

// ===== tb/slot_expander_model.sv
`timescale 1ns/10ps
module slot_expander_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Command path
  input  wire logic       cmd_issue,
  input  wire logic [3:0] busy_len,
  output logic            expander_busy
);
  // ****
  // Expander transaction timer
  // ****
  logic [3:0] left;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      left          <= 4'h0;
      expander_busy <= 1'b0;
    end else if (cmd_issue) begin
      left          <= busy_len;
      expander_busy <= 1'b1;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end else begin
      expander_busy <= 1'b0;
    end
  end
endmodule

// ===== tb/hotplug_slot_status_flags_tb.sv
`timescale 1ns/10ps
module hotplug_slot_status_flags_tb;
  logic        mclk       = 1'b0;
  logic        nrst       = 1'b0;
  logic [7:0]  address    = 8'h00;
  logic        read       = 1'b0;
  logic        write      = 1'b0;
  logic [31:0] writedata  = 32'h0;
  logic [3:0]  byteenable = 4'h0;
  logic [4:0]  pins       = 5'h08;
  logic        link       = 1'b0;
  logic [3:0]  busy_len   = 4'h2;
  logic [8:0]  flags      = 9'h000;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        cmd_issue;
  logic [15:0] cmd_data;
  logic        busy;
  logic        irq;
  logic [31:0] q;
  logic [31:0] rd_up;
  logic [31:0] q_up;
  logic [15:0] wd;
  logic [15:0] last_cmd;
  int          bad_count  = 0;
  int          num_checks = 0;
  int          ncmd       = 0;
  int          k;

  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (cmd_issue === 1'b1) begin
      ncmd++;
      last_cmd = cmd_data;
    end
  end

  hotplug_slot_status_flags dut (
    .mclk(mclk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .button_pin(pins[0]), .power_fault_pin(pins[1]),
    .latch_open_pin(pins[2]), .presence_pin(pins[3]),
    .interlock_pin(pins[4]), .link_active_indication(link),
    .cmd_issue(cmd_issue), .cmd_data(cmd_data),
    .expander_busy(busy), .hotplug_irq(irq));

  hotplug_slot_status_flags #(
    .UPSTREAM_PORT(1'b1)
  ) dut_up (
    .mclk(mclk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(rd_up), .waitrequest(),
    .button_pin(pins[0]), .power_fault_pin(pins[1]),
    .latch_open_pin(pins[2]), .presence_pin(pins[3]),
    .interlock_pin(pins[4]), .link_active_indication(link),
    .cmd_issue(), .cmd_data(),
    .expander_busy(busy), .hotplug_irq());

  slot_expander_model partner (
    .mclk(mclk), .nrst(nrst), .cmd_issue(cmd_issue),
    .busy_len(busy_len), .expander_busy(busy));

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] status_word(input logic [8:0] f,
                                              input logic [4:0] p);
    return {16'h0000, 7'h00, f[8], p[4], p[3], p[2], f[4:0]};
  endfunction

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    read       <= !wr;
    write      <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q    = readdata;
    q_up = rd_up;
    if (waitrequest !== 1'b0) begin
      bad_count++;
      complete_run();
    end
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd_stat;
    bus(1'b0, 8'h58, 32'h0, 4'hF);
    chk({16'h0000, q[31:16]}, status_word(flags, pins));
  endtask

  task automatic clr(input logic [15:0] m);
    bus(1'b1, 8'h58, {m, 16'h0000}, 4'hC);
  endtask

  task automatic settle;
    repeat (6) @(posedge mclk);
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    k = $urandom(32'hA9C77D4A);
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rd_stat();
    bus(1'b0, 8'h64, 32'h0, 4'hF);
    chk(q, 32'h0000_0020);
    chk(q_up, 32'h0);
    bus(1'b0, 8'h40, 32'h0, 4'hF);
    chk(q, 32'h0);
    bus(1'b1, 8'h68, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 8'h68, 32'h0, 4'hF);
    chk(q, 32'h0000_0020);
    chk(q_up, 32'h0);
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      pins[i] <= ~pins[i];
      settle();
      if (i < 2) pins[i] <= 1'b0;
      settle();
      flags[i] = 1'b1;
      rd_stat();
      clr(~(16'h0001 << i));
      rd_stat();
      clr(16'h0001 << i);
      flags[i] = 1'b0;
      rd_stat();
    end
    pins[4] <= 1'b1;
    settle();
    rd_stat();
    for (int i = 0; i < 2; i++) begin
      link <= ~link;
      settle();
      flags[8] = 1'b1;
      rd_stat();
      clr(16'h0100);
      flags[8] = 1'b0;
      rd_stat();
    end
    $display("test sensor_events done");
    k = ncmd;
    for (int i = 0; i < 2; i++) begin
      busy_len <= 4'h8 + 4'($urandom_range(7));
      wd = 16'($urandom_range(16'hFFFF));
      bus(1'b1, 8'h58, {16'h0000, wd}, 4'h3);
      rd_stat();
      for (int n = 0; n < 40 && busy !== 1'b0; n++) @(posedge mclk);
      if (busy !== 1'b0) begin
        bad_count++;
        complete_run();
      end
      settle();
      flags[4] = 1'b1;
      rd_stat();
      chk({16'h0000, last_cmd}, {16'h0000, wd});
    end
    chk(32'(ncmd - k), 32'h2);
    $display("test commands done");
    for (int i = 1; i < 4; i++) begin
      bus(1'b1, 8'h80, 32'(i << 4), 4'hF);
      repeat (3) @(posedge mclk);
      chk({31'h0, irq}, {31'h0, i == 3});
    end
    clr(16'h0010);
    flags[4] = 1'b0;
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rd_stat();
    $display("test interrupt done");
    complete_run();
  end
endmodule
